/* File: inc/nrrp_regs.svh */
// Timing counts, command codes and geometry for the NAND ROM read host
`ifndef NRRP_REGS_SVH
`define NRRP_REGS_SVH
`define NRRP_CMD_READ_LO    8'h00
`define NRRP_CMD_READ_HI    8'h01
`define NRRP_CMD_READ_SPARE 8'h50
`define NRRP_CMD_RESET      8'hff
`define NRRP_CLK_NS         25
`define NRRP_PAGE_BYTES     528
`define NRRP_SPARE_BYTES    16
`define NRRP_BLOCK_PAGES    32
// Strobe low and high phases, least times rounded up to cycles
`define NRRP_WP_NS          25
`define NRRP_WH_NS          25
`define NRRP_WP_CYC         ((`NRRP_WP_NS + `NRRP_CLK_NS - 1) / `NRRP_CLK_NS)
`define NRRP_WH_CYC         ((`NRRP_WH_NS + `NRRP_CLK_NS - 1) / `NRRP_CLK_NS)
`define NRRP_RP_NS          50
`define NRRP_RP_CYC         ((`NRRP_RP_NS + `NRRP_CLK_NS - 1) / `NRRP_CLK_NS)
// Wait before sampling ready/busy: covers write_to_busy_delay of 200 ns
`define NRRP_WB_NS          200
`define NRRP_WB_CYC         ((`NRRP_WB_NS + `NRRP_CLK_NS - 1) / `NRRP_CLK_NS + 1)
`define NRRP_WHR_NS         50
`define NRRP_WHR_CYC        ((`NRRP_WHR_NS + `NRRP_CLK_NS - 1) / `NRRP_CLK_NS)
`endif

/* File: inc/nrrp_pkg.sv */
// Types for the NAND ROM read host
package nrrp_pkg;
  typedef enum logic [3:0] {
    NRRP_IDLE  = 4'h0,
    NRRP_CMD   = 4'h1,
    NRRP_ADDR  = 4'h3,
    NRRP_WAITB = 4'h2,
    NRRP_WAITR = 4'h6,
    NRRP_READ  = 4'h7,
    NRRP_GAP   = 4'h5,
    NRRP_STOP  = 4'h4
  } nrrp_state_t;

  typedef struct packed {
    logic ce_n;
    logic cle;
    logic ale;
    logic we_n;
    logic output_strobe_n;
  } nrrp_pins_t;

  typedef struct packed {
    nrrp_state_t state;
    nrrp_pins_t  pins;
    logic [7:0]  bus_out;
    logic        bus_oe;
    logic [7:0]  cmd;
    logic [23:0] addr;
    logic [1:0]  acnt;
    logic [3:0]  tcnt;
    logic [9:0]  col;
    logic [4:0]  page;
    logic [15:0] left;
    logic        busy;
    logic        done;
    logic        rd_valid;
    logic [7:0]  rd_data;
    logic        rd_last;
  } nrrp_st_t;
endpackage : nrrp_pkg

/* File: hw/nrrp_host.sv */
// Host controller that reads a NAND-style ROM through its pins
// Behaviour
// - Command byte with command latch high, address byte with address latch high.
// - Only codes 00, 01, 50 and FF are ever issued.
// - While busy only reset may be issued; reset works when busy.
// - Three address bytes, low first: bits 0-7, 9-16, 17-24.
// - After block end host stops and needs a new command and address.
// - No output strobe after a page end until ready, nor outside output.
// - After power-up select held high and reset issued.
// - Address bytes always follow the read command directly.
// - After reset or select high a new command and address precede reading.
`timescale 1ns/1ps
`default_nettype none
`include "nrrp_regs.svh"
module nrrp_host #(
  parameter int COUNT_W = 16
) (
  input  wire logic               clk_sys,
  input  wire logic               rst_n,
  input  wire logic               req_valid,
  input  wire logic [1:0]         req_mode,
  input  wire logic [23:0]        req_addr,
  input  wire logic [7:0]         req_column,
  input  wire logic [COUNT_W-1:0] req_count,
  input  wire logic               req_reset,
  output logic                    req_ready,
  output logic                    rd_valid,
  output logic [7:0]              rd_data,
  output logic                    rd_last,
  output logic                    chip_select_n,
  output logic                    cmd_latch,
  output logic                    addr_latch,
  output logic                    write_strobe_n,
  output logic                    output_strobe_n,
  input  wire logic [7:0]         shared_byte_bus_in,
  output logic [7:0]              shared_byte_bus_out,
  output logic                    shared_byte_bus_oe,
  input  wire logic               ready_busy_n
);
  nrrp_pkg::nrrp_st_t s_r, s_nxt;

  logic [9:0] page_end;
  always_comb begin
    page_end = 10'(`NRRP_PAGE_BYTES - 1);
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.rd_valid = 1'b0;
    s_nxt.rd_last = 1'b0;
    if (s_r.tcnt != 4'h0) begin
      s_nxt.tcnt = s_r.tcnt - 4'h1;
    end
    unique case (s_r.state)
      nrrp_pkg::NRRP_IDLE: begin
        s_nxt.pins = '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1, output_strobe_n: 1'b1};
        s_nxt.bus_oe = 1'b0;
        // A read waits for ready; only reset may be sent to a busy device
        if ((req_valid && (req_reset || ready_busy_n)) || s_r.busy) begin
          s_nxt.busy = 1'b0;
          // Power-up and explicit resets both send the reset command
          if (s_r.busy || req_reset) begin
            s_nxt.cmd = `NRRP_CMD_RESET;
          end else begin
            unique case (req_mode)
              2'h0: s_nxt.cmd = `NRRP_CMD_READ_LO;
              2'h1: s_nxt.cmd = `NRRP_CMD_READ_HI;
              default: s_nxt.cmd = `NRRP_CMD_READ_SPARE;
            endcase
          end
          // Mode bit 8 is carried by the command, so only a column byte is sent
          s_nxt.addr = {req_addr[23:8],
                        (req_mode > 2'h1) ? {4'h0, req_column[3:0]} : req_column};
          s_nxt.col = (req_mode == 2'h0) ? {2'b00, req_column} :
                      (req_mode == 2'h1) ? {2'b01, req_column} :
                      10'(512) + {6'h00, req_column[3:0]};
          s_nxt.page = req_addr[12:8];
          s_nxt.left = 16'(req_count);
          s_nxt.acnt = 2'h0;
          s_nxt.pins.ce_n = 1'b0;
          s_nxt.pins.cle = 1'b1;
          s_nxt.pins.we_n = 1'b0;
          s_nxt.bus_oe = 1'b1;
          s_nxt.bus_out = (s_r.busy || req_reset) ? `NRRP_CMD_RESET : 8'h00;
          if (!(s_r.busy || req_reset)) begin
            s_nxt.bus_out = (req_mode == 2'h0) ? `NRRP_CMD_READ_LO :
                            (req_mode == 2'h1) ? `NRRP_CMD_READ_HI : `NRRP_CMD_READ_SPARE;
          end
          s_nxt.tcnt = 4'(`NRRP_WP_CYC);
          s_nxt.state = nrrp_pkg::NRRP_CMD;
        end
      end
      nrrp_pkg::NRRP_CMD, nrrp_pkg::NRRP_ADDR: begin
        if (s_r.tcnt == 4'h0) begin
          if (!s_r.pins.we_n) begin
            s_nxt.pins.we_n = 1'b1;
            s_nxt.tcnt = 4'(`NRRP_WH_CYC);
          end else if (s_r.state == nrrp_pkg::NRRP_CMD && s_r.cmd == `NRRP_CMD_RESET) begin
            s_nxt.pins.cle = 1'b0;
            s_nxt.bus_oe = 1'b0;
            s_nxt.tcnt = 4'(`NRRP_WB_CYC);
            s_nxt.state = nrrp_pkg::NRRP_WAITB;
          end else if (s_r.state == nrrp_pkg::NRRP_ADDR && s_r.acnt == 2'h2) begin
            s_nxt.pins.ale = 1'b0;
            s_nxt.bus_oe = 1'b0;
            s_nxt.tcnt = 4'(`NRRP_WB_CYC);
            s_nxt.state = nrrp_pkg::NRRP_WAITB;
          end else begin
            // Address bytes follow the command with no gap
            if (s_r.state == nrrp_pkg::NRRP_ADDR) begin
              s_nxt.acnt = s_r.acnt + 2'h1;
            end
            s_nxt.pins.cle = 1'b0;
            s_nxt.pins.ale = 1'b1;
            s_nxt.pins.we_n = 1'b0;
            s_nxt.bus_out = s_r.addr[8*s_nxt.acnt +: 8];
            s_nxt.tcnt = 4'(`NRRP_WP_CYC);
            s_nxt.state = nrrp_pkg::NRRP_ADDR;
          end
        end
      end
      nrrp_pkg::NRRP_WAITB: begin
        // Ready is not sampled until the busy delay has passed
        if (s_r.tcnt == 4'h0) begin
          s_nxt.state = nrrp_pkg::NRRP_WAITR;
        end
      end
      nrrp_pkg::NRRP_WAITR: begin
        if (ready_busy_n) begin
          if (s_r.cmd == `NRRP_CMD_RESET || s_r.left == 16'h0000) begin
            s_nxt.state = nrrp_pkg::NRRP_STOP;
          end else begin
            s_nxt.tcnt = 4'(`NRRP_WHR_CYC);
            s_nxt.state = nrrp_pkg::NRRP_GAP;
          end
        end
      end
      nrrp_pkg::NRRP_GAP: begin
        if (s_r.tcnt == 4'h0) begin
          s_nxt.pins.output_strobe_n = 1'b0;
          s_nxt.tcnt = 4'(`NRRP_RP_CYC);
          s_nxt.state = nrrp_pkg::NRRP_READ;
        end
      end
      nrrp_pkg::NRRP_READ: begin
        if (s_r.tcnt == 4'h0) begin
          // Data sampled at end of low phase, before the rising edge
          s_nxt.pins.output_strobe_n = 1'b1;
          s_nxt.rd_valid = 1'b1;
          s_nxt.rd_data = shared_byte_bus_in;
          s_nxt.left = s_r.left - 16'h0001;
          s_nxt.rd_last = (s_r.left == 16'h0001);
          s_nxt.tcnt = 4'(`NRRP_WH_CYC);
          if (s_r.left == 16'h0001) begin
            s_nxt.state = nrrp_pkg::NRRP_STOP;
          end else if (s_r.col == page_end) begin
            s_nxt.col = (s_r.cmd == `NRRP_CMD_READ_SPARE) ? 10'(512) : 10'h000;
            s_nxt.page = s_r.page + 5'h01;
            // Block end needs a fresh command; stop rather than wrap
            s_nxt.state = (s_r.page == 5'(`NRRP_BLOCK_PAGES - 1)) ?
                          nrrp_pkg::NRRP_STOP : nrrp_pkg::NRRP_WAITB;
            s_nxt.tcnt = 4'(`NRRP_WB_CYC);
          end else begin
            s_nxt.col = s_r.col + 10'h001;
            s_nxt.state = nrrp_pkg::NRRP_GAP;
          end
        end
      end
      nrrp_pkg::NRRP_STOP: begin
        // Dropping select ends the read; later reads reissue command and address
        s_nxt.pins.ce_n = 1'b1;
        if (s_r.tcnt == 4'h0) begin
          s_nxt.state = nrrp_pkg::NRRP_IDLE;
        end
      end
      default: s_nxt.state = nrrp_pkg::NRRP_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
      s_r.state <= nrrp_pkg::NRRP_IDLE;
      s_r.pins <= 5'b10011;
      s_r.busy <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      req_ready <= 1'b0;
    end else begin
      req_ready <= (s_nxt.state == nrrp_pkg::NRRP_IDLE) && !s_nxt.busy && ready_busy_n;
    end
  end

  assign rd_valid            = s_r.rd_valid;
  assign rd_data             = s_r.rd_data;
  assign rd_last             = s_r.rd_last;
  assign chip_select_n       = s_r.pins.ce_n;
  assign cmd_latch           = s_r.pins.cle;
  assign addr_latch          = s_r.pins.ale;
  assign write_strobe_n      = s_r.pins.we_n;
  assign output_strobe_n     = s_r.pins.output_strobe_n;
  assign shared_byte_bus_out = s_r.bus_out;
  assign shared_byte_bus_oe  = s_r.bus_oe;
endmodule : nrrp_host
`default_nettype wire

/* File: testbench/nrrp_dev_model.sv */
// Behavioural model of the read-only NAND-style device
`timescale 1ns/1ps
`default_nettype none
module nrrp_dev_model #(
  parameter int LOAD_CYC = 40
) (
  input wire logic       clk_sys,
  input wire logic       chip_select_n,
  input wire logic       cmd_latch,
  input wire logic       addr_latch,
  input wire logic       write_strobe_n,
  input wire logic       output_strobe_n,
  input wire logic [7:0] bus_from_host,
  output logic     [7:0] bus_to_host,
  output logic           ready_busy_n
);
  logic [7:0] cmd = 8'h00, last = 8'h00, cur;
  logic [9:0] col = 10'h000;
  logic [4:0] page = 5'h00;
  logic [1:0] acnt = 2'h0;
  logic       we_q = 1'h1, re_q = 1'h1, pend = 1'h0;
  int         busy_cnt = 0, resets = 0;
  assign cur = (col >= 10'd512) ? 8'hff : col[7:0] ^ {3'h0, page};
  // Released bus shows the inverse of the last byte: no pull resistor
  assign bus_to_host = (!chip_select_n && !output_strobe_n) ? cur : ~last;
  assign ready_busy_n = (busy_cnt == 0);
  always @(posedge clk_sys) begin
    if (busy_cnt > 0) busy_cnt <= busy_cnt - 1;
    // A deselect right after a page's last byte cancels the next page load
    pend <= 1'h0;
    if (pend && !chip_select_n) busy_cnt <= LOAD_CYC;
    we_q <= write_strobe_n;
    re_q <= output_strobe_n;
    if (!chip_select_n && write_strobe_n && !we_q) begin
      if (cmd_latch && (busy_cnt == 0 || bus_from_host == 8'hff)) begin
        cmd <= bus_from_host;
        acnt <= 2'h0;
        if (bus_from_host == 8'hff) begin
          busy_cnt <= 20;
          resets <= resets + 1;
        end
      end else if (addr_latch) begin
        acnt <= acnt + 2'h1;
        if (acnt == 2'h0) col <= (cmd == 8'h50) ? {6'h20, bus_from_host[3:0]}
                                 : {1'h0, cmd == 8'h01, bus_from_host};
        if (acnt == 2'h1) page <= bus_from_host[4:0];
        if (acnt == 2'h2) busy_cnt <= LOAD_CYC;
      end
    end
    if (!chip_select_n && output_strobe_n && !re_q) begin
      last <= cur;
      if (col != 10'd527) col <= col + 10'h1;
      else if (page != 5'h1f) begin // Block end: no further page load
        col <= (cmd == 8'h50) ? 10'h200 : 10'h000;
        page <= page + 5'h1;
        pend <= 1'h1;
      end
    end
  end
endmodule : nrrp_dev_model
`default_nettype wire

/* File: testbench/nrrp_host_chk.sv */
// Pin protocol checker for the NAND ROM read host
`timescale 1ns/1ps
`default_nettype none
module nrrp_host_chk (
  input wire logic       clk_sys,
  input wire logic       rst_n,
  input wire logic       req_ready,
  input wire logic       chip_select_n,
  input wire logic       cmd_latch,
  input wire logic       addr_latch,
  input wire logic       write_strobe_n,
  input wire logic       output_strobe_n,
  input wire logic [7:0] shared_byte_bus_out,
  input wire logic       shared_byte_bus_oe,
  input wire logic       ready_busy_n
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_latch_excl: assert property (cmd_latch |-> !addr_latch)
    else $error("both latches high");
  a_write_cycle: assert property ($fell(write_strobe_n) |-> !chip_select_n &&
    (cmd_latch ^ addr_latch) && shared_byte_bus_oe) else $error("bad write cycle");
  a_read_no_drive: assert property (!output_strobe_n |-> !shared_byte_bus_oe)
    else $error("host drives during read");
  a_cmd_known: assert property (cmd_latch && !write_strobe_n |->
    shared_byte_bus_out inside {8'h00, 8'h01, 8'h50, 8'hff}) else $error("unknown command");
  a_busy_reset_only: assert property (cmd_latch && !write_strobe_n && !ready_busy_n
    |-> shared_byte_bus_out == 8'hff) else $error("command while busy");
  a_strobe_ready: assert property ($fell(output_strobe_n) |-> ready_busy_n &&
    !chip_select_n && !cmd_latch && !addr_latch && write_strobe_n) else $error("bad strobe");
  a_addr_follows: assert property ($rose(cmd_latch) && shared_byte_bus_out != 8'hff
    |-> ##[1:8] addr_latch) else $error("no address after read command");
  a_busy_wait: assert property ($fell(addr_latch) |-> output_strobe_n [*8])
    else $error("strobe too soon after address");
  a_idle_deselect: assert property (req_ready |-> chip_select_n && output_strobe_n)
    else $error("selected while idle");
endmodule : nrrp_host_chk
bind nrrp_host nrrp_host_chk u_chk (.clk_sys(clk_sys), .rst_n(rst_n), .req_ready(req_ready),
  .chip_select_n(chip_select_n), .cmd_latch(cmd_latch), .addr_latch(addr_latch),
  .write_strobe_n(write_strobe_n), .output_strobe_n(output_strobe_n),
  .shared_byte_bus_out(shared_byte_bus_out), .shared_byte_bus_oe(shared_byte_bus_oe),
  .ready_busy_n(ready_busy_n));
`default_nettype wire

/* File: testbench/nrrp_host_test.sv */
// Self-checking bench: NAND ROM read host against the device model
`timescale 1ns/1ps
`default_nettype none
module nrrp_host_test;
  logic        clk_sys = 1'h0, rst_n = 1'h0, req_valid = 1'h0, req_reset = 1'h0;
  logic        req_ready, rd_valid, rd_last, cs_n, cl, al, we_n, re_n, oe, rb_n;
  logic [1:0]  req_mode = 2'h0;
  logic [23:0] req_addr = 24'h0;
  logic [7:0]  req_column = 8'h00, rd_data, bus_out, dev_bus, bus_in;
  logic [15:0] req_count = 16'h0;
  int          failures = 0, num_checks = 0, cyc = 0;
  assign bus_in = oe ? bus_out : dev_bus;
  nrrp_host DUT (.clk_sys(clk_sys), .rst_n(rst_n), .req_valid(req_valid), .req_mode(req_mode),
    .req_addr(req_addr), .req_column(req_column), .req_count(req_count), .req_reset(req_reset),
    .req_ready(req_ready), .rd_valid(rd_valid), .rd_data(rd_data), .rd_last(rd_last),
    .chip_select_n(cs_n), .cmd_latch(cl), .addr_latch(al), .write_strobe_n(we_n),
    .output_strobe_n(re_n), .shared_byte_bus_in(bus_in), .shared_byte_bus_out(bus_out),
    .shared_byte_bus_oe(oe), .ready_busy_n(rb_n));
  nrrp_dev_model #(.LOAD_CYC(40)) dev (.clk_sys(clk_sys), .chip_select_n(cs_n), .cmd_latch(cl),
    .addr_latch(al), .write_strobe_n(we_n), .output_strobe_n(re_n), .bus_from_host(bus_in),
    .bus_to_host(dev_bus), .ready_busy_n(rb_n));
  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      failures++;
      tally_and_finish();
    end
  end
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic wait_ready;
    for (int k = 0; k < 3000 && req_ready !== 1'h1; k++) @(negedge clk_sys);
    check("req_ready", 16'h1, {15'h0, req_ready});
  endtask : wait_ready
  // Expected bytes follow the page layout; block end may cut the read short
  task automatic do_read(input logic [1:0] m, input logic [4:0] pg, input logic [7:0] c,
                         input logic [15:0] n, input int nexp);
    int got;
    logic [9:0] col;
    logic [4:0] p;
    got = 0;
    p = pg;
    col = m[1] ? {6'h20, c[3:0]} : {1'h0, m[0], c};
    req_mode = m;
    req_addr = {11'h0, pg, 8'h00};
    req_column = c;
    req_count = n;
    req_valid = 1'h1;
    @(negedge clk_sys);
    req_valid = 1'h0;
    for (int k = 0; k < 30000 && !(k > 2 && req_ready === 1'h1); k++) begin
      @(negedge clk_sys);
      if (rd_valid === 1'h1) begin
        check("rd_data", (col >= 10'd512) ? 16'h00ff : {8'h0, col[7:0] ^ {3'h0, p}}, rd_data);
        check("rd_last", {15'h0, got == nexp - 1 && n == nexp}, {15'h0, rd_last});
        got++;
        if (col == 10'd527) begin
          col = m[1] ? 10'h200 : 10'h000;
          p++;
        end else col++;
      end
    end
    check("byte_count", nexp[15:0], got[15:0]);
  endtask : do_read
  task automatic t_power_up;
    wait_ready();
    check("reset_count", 16'h1, dev.resets[15:0]);
  endtask : t_power_up
  task automatic t_main_area;
    do_read(2'h0, 5'h02, 8'h03, 16'h4, 4);
    do_read(2'h1, 5'h05, 8'hff, 16'h2, 2);
  endtask : t_main_area
  task automatic t_spare_area;
    do_read(2'h2, 5'h00, 8'hf3, 16'h3, 3);
    do_read(2'h3, 5'h07, 8'h0f, 16'h3, 3);
  endtask : t_spare_area
  task automatic t_block_end;
    do_read(2'h2, 5'h1f, 8'h0e, 16'h5, 2);
  endtask : t_block_end
  // Count ends on a page's last byte: the quick deselect must keep the device ready
  task automatic t_page_end_stop;
    do_read(2'h2, 5'h04, 8'h0f, 16'h1, 1);
    check("ready_busy_n", 16'h1, {15'h0, rb_n});
    do_read(2'h0, 5'h04, 8'h10, 16'h1, 1);
  endtask : t_page_end_stop
  task automatic t_reset_cmd;
    req_reset = 1'h1;
    req_valid = 1'h1;
    @(negedge clk_sys);
    req_valid = 1'h0;
    req_reset = 1'h0;
    repeat (3) @(negedge clk_sys);
    wait_ready();
    check("reset_count", 16'h2, dev.resets[15:0]);
    do_read(2'h0, 5'h01, 8'h00, 16'h2, 2);
  endtask : t_reset_cmd
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (12) @(negedge clk_sys);
    rst_n = 1'h1;
    t_power_up();
    t_main_area();
    t_spare_area();
    t_block_end();
    t_page_end_stop();
    t_reset_cmd();
    tally_and_finish();
  end
endmodule : nrrp_host_test
`default_nettype wire
